// >>> nss_defines.svh
// register offsets, field positions, reset values and timing counts
`ifndef NSS_DEFINES_SVH
`define NSS_DEFINES_SVH
`define NSS_OFF_STATUS    12'h000
`define NSS_OFF_CONTROL   12'h004
`define NSS_OFF_TIMEOUT   12'h008
`define NSS_OFF_STATE     12'h00C
`define NSS_OFF_IRQ_STAT  12'h010
`define NSS_OFF_IRQ_MASK  12'h014
`define NSS_OFF_CID_LEN   12'h018
`define NSS_OFF_CID_DATA  12'h01C
`define NSS_OFF_CID_PTR   12'h020
`define NSS_BIT_LINK      0
`define NSS_BIT_IP        1
`define NSS_BIT_PORT1     3
`define NSS_BIT_PORT2     4
`define NSS_CTL_ACD       0
`define NSS_CTL_SRC_LO    1
`define NSS_CTL_SRC_HI    2
`define NSS_CTL_RESET     32'h0000_0001
`define NSS_CID_MAX       64
`define NSS_TICK_US       1
`define NSS_CLK_MHZ       50
`define NSS_TICK_CYCLES   (`NSS_TICK_US * `NSS_CLK_MHZ)
`endif

// >>> nss_pkg.sv
// types shared by the network state supervisor
package nss_pkg;
  typedef enum logic [2:0] {
    NSS_WAIT_PROCESS,
    NSS_PROCESS_ACTIVE,
    NSS_ERROR,
    NSS_IDLE,
    NSS_EXCEPTION
  } nss_state_e;
  typedef enum logic [1:0] {
    NSS_CID_OFF,
    NSS_CID_STATION,
    NSS_CID_HOSTNAME,
    NSS_CID_GENERIC
  } nss_cid_src_e;
  typedef struct packed {
    logic link_port1;
    logic link_port2;
    logic ip_assigned_flag;
    logic ip_conflict;
    logic modbus_request;
    logic idle_write;
    logic idle_enter;
    logic watchdog_timeout;
  } nss_events_s;
endpackage : nss_pkg

// >>> nss_cid_mem.sv
// client identifier byte store with registered read data
`timescale 1ns/1ps
`default_nettype none
module nss_cid_mem #(
  parameter int DEPTH = 64
) (
  // clock
  input  wire logic                     clock,
  input  wire logic                     ce,
  // write port
  input  wire logic                     wr_en,
  input  wire logic [$clog2(DEPTH)-1:0] wr_addr,
  input  wire logic [7:0]               wr_data,
  // read port
  input  wire logic [$clog2(DEPTH)-1:0] rd_addr,
  output var  logic [7:0]               rd_data
);
  logic [7:0] mem [DEPTH];
  always_ff @(posedge clock) begin
    if (ce && wr_en) begin
      mem[wr_addr] <= wr_data;
    end
  end
  always_ff @(posedge clock) begin
    if (ce) begin
      rd_data <= mem[rd_addr];
    end
  end
endmodule : nss_cid_mem
`default_nettype wire

// >>> nss_supervisor.sv
// network state supervisor with apb register file
// How it works
// R1: status bit 0 high when any ethernet port senses link
// R2: status bit 1 high while an ip address is established
// R3: readers must ignore reserved bits 2 and 5 to 15
// R4: status bit 3 mirrors link state of port one
// R5: status bit 4 mirrors link state of port two
// R6: identifier source 0 off (default), 1 station, 2 host name, 3 string
// R7: generic string is type plus identifier, at most 64 octets
// R8: with source 2 the generic string is ignored
// R9: configuring party keeps the identifier unique in its domain
// R10: supervised flag only in process active with nonzero timeout
// R11: waiting moves to process active on a modbus request
// R12: process active returns to waiting when timeout expires without request
// R13: ip conflict enters error only if conflict detection on (default on)
// R14: idle entered and exited only by write to idle register 1004h; ip conflict also leaves idle for error, watchdog for exception
// R15: in exception every modbus request is discarded
// R16: watchdog timeout stops network participation and enters exception
// R17: after reset all status bits and supervised flag are clear
`timescale 1ns/1ps
`default_nettype none
`include "nss_defines.svh"
module nss_supervisor
  import nss_pkg::*;
#(
  parameter int CID_DEPTH   = `NSS_CID_MAX,
  parameter int TICK_CYCLES = `NSS_TICK_CYCLES
) (
  // clock and reset
  input  wire logic        clock,
  input  wire logic        reset_n,
  input  wire logic        ce,
  // apb slave
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [11:0] paddr,
  input  wire logic [31:0] pwdata,
  output logic             pready,
  output logic             pslverr,
  output var  logic [31:0] prdata,
  // network events
  input  wire nss_events_s events,
  // status outputs
  output var  logic [15:0] network_status_bits,
  output var  logic        supervised,
  output var  logic        network_enable,
  output var  logic        request_accept,
  output var  logic [1:0]  cid_source,
  output logic             irq
);
  localparam int AW = $clog2(CID_DEPTH);

  nss_state_e  state;
  nss_state_e  next_state;
  logic [31:0] control;
  logic [15:0] timeout_ms;
  logic [31:0] tmo_count;
  logic [31:0] tick_count;
  logic [4:0]  irq_stat;
  logic [4:0]  irq_mask;
  logic [6:0]  cid_len;
  logic [AW-1:0] cid_ptr;
  logic [7:0]  cid_rd;
  logic        acd_en;
  logic        wr;
  logic        rd;
  logic        tick;
  logic        expired;
  logic        mapped;
  logic [4:0]  ev;
  nss_cid_src_e src;

  assign pready  = 1'b1;
  assign wr      = psel && penable && pwrite;
  assign rd      = psel && penable && !pwrite;
  assign acd_en  = control[`NSS_CTL_ACD];
  assign src     = nss_cid_src_e'(control[`NSS_CTL_SRC_HI:`NSS_CTL_SRC_LO]);
  assign pslverr = psel && penable && !mapped;
  assign irq     = |(irq_stat & irq_mask);

  // address decode; an unmapped word answers with an error and reads zero
  always_comb begin
    mapped = 1'b0;
    if (paddr == `NSS_OFF_STATUS) begin
      mapped = 1'b1;
    end else if (paddr == `NSS_OFF_CONTROL) begin
      mapped = 1'b1;
    end else if (paddr == `NSS_OFF_TIMEOUT) begin
      mapped = 1'b1;
    end else if (paddr == `NSS_OFF_STATE) begin
      mapped = 1'b1;
    end else if (paddr == `NSS_OFF_IRQ_STAT) begin
      mapped = 1'b1;
    end else if (paddr == `NSS_OFF_IRQ_MASK) begin
      mapped = 1'b1;
    end else if (paddr == `NSS_OFF_CID_LEN) begin
      mapped = 1'b1;
    end else if (paddr == `NSS_OFF_CID_DATA) begin
      mapped = 1'b1;
    end else if (paddr == `NSS_OFF_CID_PTR) begin
      mapped = 1'b1;
    end
  end

  // status reflects link and address inputs, reserved bits read zero
  always_ff @(posedge clock) begin
    if (!reset_n) begin
      network_status_bits <= 16'h0000; // R17
    end else if (ce) begin
      network_status_bits <= 16'h0000; // R3
      network_status_bits[`NSS_BIT_LINK]  <= events.link_port1 | events.link_port2; // R1
      network_status_bits[`NSS_BIT_IP]    <= events.ip_assigned_flag; // R2
      network_status_bits[`NSS_BIT_PORT1] <= events.link_port1; // R4
      network_status_bits[`NSS_BIT_PORT2] <= events.link_port2; // R5
    end
  end

  // control register: conflict detection on, source off after reset
  always_ff @(posedge clock) begin
    if (!reset_n) begin
      control    <= `NSS_CTL_RESET; // R13 R6
      timeout_ms <= 16'h0000;
      irq_mask   <= 5'h00;
    end else if (ce && wr) begin
      if (paddr == `NSS_OFF_CONTROL) begin
        control <= {29'h0, pwdata[2:0]};
      end else if (paddr == `NSS_OFF_TIMEOUT) begin
        timeout_ms <= pwdata[15:0];
      end else if (paddr == `NSS_OFF_IRQ_MASK) begin
        irq_mask <= pwdata[4:0];
      end
    end
  end

  // generic string store, length clamps at 64 octets and the data pointer wraps to byte 0
  always_ff @(posedge clock) begin
    if (!reset_n) begin
      cid_len <= 7'h00;
      cid_ptr <= '0;
    end else if (ce && wr) begin
      if (paddr == `NSS_OFF_CID_LEN) begin
        cid_len <= (pwdata[7:0] > 8'(CID_DEPTH)) ? 7'(CID_DEPTH) : pwdata[6:0]; // R7
      end else if (paddr == `NSS_OFF_CID_PTR) begin
        cid_ptr <= pwdata[AW-1:0];
      end else if (paddr == `NSS_OFF_CID_DATA) begin
        cid_ptr <= cid_ptr + 1'b1;
      end
    end else if (ce && rd && paddr == `NSS_OFF_CID_DATA) begin
      cid_ptr <= cid_ptr + 1'b1;
    end
  end

  nss_cid_mem #(.DEPTH(CID_DEPTH)) u_cid_mem (
    .clock   (clock),
    .ce      (ce),
    .wr_en   (wr && paddr == `NSS_OFF_CID_DATA),
    .wr_addr (cid_ptr),
    .wr_data (pwdata[7:0]),
    .rd_addr (cid_ptr),
    .rd_data (cid_rd)
  );

  // source 2 and 1 never consult the string; only 3 does
  always_ff @(posedge clock) begin
    if (!reset_n) begin
      cid_source <= 2'b00;
    end else if (ce) begin
      cid_source <= (src == NSS_CID_GENERIC && cid_len == 7'h00) ? 2'b00 : src; // R6 R8
    end
  end

  // millisecond tick restarts with every request so a timeout is never cut short
  assign tick = (tick_count == 32'(TICK_CYCLES * 1000 - 1));
  always_ff @(posedge clock) begin
    if (!reset_n) begin
      tick_count <= 32'h0;
    end else if (ce) begin
      if (state != NSS_PROCESS_ACTIVE || events.modbus_request || tick) begin // R12
        tick_count <= 32'h0;
      end else begin
        tick_count <= tick_count + 32'h1;
      end
    end
  end

  assign expired = (timeout_ms != 16'h0000) && (tmo_count >= {16'h0, timeout_ms});
  always_ff @(posedge clock) begin
    if (!reset_n) begin
      tmo_count <= 32'h0;
    end else if (ce) begin
      if (state != NSS_PROCESS_ACTIVE || events.modbus_request) begin
        tmo_count <= 32'h0;
      end else if (tick) begin
        tmo_count <= tmo_count + 32'h1;
      end
    end
  end

  // state machine; watchdog has highest priority and exception is final
  always_comb begin
    next_state = state;
    case (state)
      NSS_WAIT_PROCESS: begin
        if (events.modbus_request) begin
          next_state = NSS_PROCESS_ACTIVE; // R11
        end
      end
      NSS_PROCESS_ACTIVE: begin
        if (expired && !events.modbus_request) begin
          next_state = NSS_WAIT_PROCESS; // R12
        end
      end
      NSS_IDLE: begin
        if (events.idle_write && !events.idle_enter) begin
          next_state = NSS_WAIT_PROCESS; // R14
        end
      end
      default: next_state = state;
    endcase
    if (state != NSS_EXCEPTION && state != NSS_ERROR) begin
      if (events.idle_write && events.idle_enter) begin
        next_state = NSS_IDLE; // R14
      end
      if (events.ip_conflict && acd_en) begin
        next_state = NSS_ERROR; // R13
      end
    end
    if (events.watchdog_timeout) begin
      next_state = NSS_EXCEPTION; // R16
    end
  end

  always_ff @(posedge clock) begin
    if (!reset_n) begin
      state <= NSS_WAIT_PROCESS;
    end else if (ce) begin
      state <= next_state;
    end
  end

  // outputs follow next_state so they change on the same edge as the state
  always_ff @(posedge clock) begin
    if (!reset_n) begin
      supervised     <= 1'b0; // R17
      network_enable <= 1'b0;
      request_accept <= 1'b0;
    end else if (ce) begin
      supervised     <= (next_state == NSS_PROCESS_ACTIVE) && (timeout_ms != 16'h0000); // R10
      network_enable <= (next_state != NSS_EXCEPTION); // R16
      request_accept <= (next_state != NSS_EXCEPTION); // R15
    end
  end

  // sticky events; a new event wins over the read that clears
  assign ev = {events.watchdog_timeout, events.ip_conflict && acd_en,
               state == NSS_PROCESS_ACTIVE && next_state == NSS_WAIT_PROCESS,
               events.modbus_request && state == NSS_WAIT_PROCESS,
               events.link_port1 ^ network_status_bits[`NSS_BIT_PORT1]};
  always_ff @(posedge clock) begin
    if (!reset_n) begin
      irq_stat <= 5'h00;
    end else if (ce) begin
      if (rd && paddr == `NSS_OFF_IRQ_STAT) begin
        // clear only what the read reported; prdata still holds it
        irq_stat <= (irq_stat & ~prdata[4:0]) | ev;
      end else begin
        irq_stat <= irq_stat | ev;
      end
    end
  end

  // read mux; cid data is the byte at the pointer from the registered store
  // limitation: a data read right after another sees the byte before the increment
  always_ff @(posedge clock) begin
    if (!reset_n) begin
      prdata <= 32'h0;
    end else if (ce && psel && !penable && !pwrite) begin
      if (paddr == `NSS_OFF_STATUS) begin
        prdata <= {16'h0, network_status_bits};
      end else if (paddr == `NSS_OFF_CONTROL) begin
        prdata <= control;
      end else if (paddr == `NSS_OFF_TIMEOUT) begin
        prdata <= {16'h0, timeout_ms};
      end else if (paddr == `NSS_OFF_STATE) begin
        prdata <= {28'h0, supervised, state};
      end else if (paddr == `NSS_OFF_IRQ_STAT) begin
        prdata <= {27'h0, irq_stat};
      end else if (paddr == `NSS_OFF_IRQ_MASK) begin
        prdata <= {27'h0, irq_mask};
      end else if (paddr == `NSS_OFF_CID_LEN) begin
        prdata <= {25'h0, cid_len};
      end else if (paddr == `NSS_OFF_CID_DATA) begin
        prdata <= {24'h0, cid_rd};
      end else if (paddr == `NSS_OFF_CID_PTR) begin
        prdata <= {{(32-AW){1'b0}}, cid_ptr};
      end else begin
        prdata <= 32'h0;
      end
    end
  end
endmodule : nss_supervisor
`default_nettype wire

// >>> nss_net_model.sv
// network side model driving the supervisor event inputs
`timescale 1ns/1ps
`default_nettype none
module nss_net_model
  import nss_pkg::*;
(
  // clock
  input  wire logic        clock,
  // events to the supervisor
  output var  nss_events_s events
);
  initial events = '0;
  // one-cycle strobe: request, idle write or watchdog
  task automatic pulse(input int b);
    @(posedge clock) events[b] <= 1'b1;
    @(posedge clock) events[b] <= 1'b0;
  endtask : pulse
  // levels stay until changed: links, address, conflict, idle value
  task automatic level(input int b, input logic v);
    @(posedge clock) events[b] <= v;
  endtask : level
endmodule : nss_net_model
`default_nettype wire

// >>> nss_supervisor_asserts.sv
// port checks for the network state supervisor
`timescale 1ns/1ps
`default_nettype none
module nss_supervisor_asserts
  import nss_pkg::*;
(
  // clock and reset
  input wire logic        clock,
  input wire logic        reset_n,
  input wire logic        ce,
  // apb
  input wire logic        psel,
  input wire logic        penable,
  input wire logic        pslverr,
  // network side
  input wire nss_events_s events,
  input wire logic [15:0] network_status_bits,
  input wire logic        supervised,
  input wire logic        network_enable,
  input wire logic        request_accept
);
  default clocking @(posedge clock); endclocking
  default disable iff (!reset_n);
  // status lags one cycle, so skip an edge after release or after a frozen cycle
  sequence s_run;
    reset_n && $past(reset_n) && $past(ce);
  endsequence
  sequence s_wd;
    events.watchdog_timeout && ce;
  endsequence
  AST_LINK: assert property (s_run |-> network_status_bits[0] ==
    $past(events.link_port1 | events.link_port2)) else $error("any link bit wrong");
  AST_IP: assert property (s_run |->
    network_status_bits[1] == $past(events.ip_assigned_flag)) else $error("ip bit wrong");
  AST_PORT1: assert property (s_run |->
    network_status_bits[3] == $past(events.link_port1)) else $error("port1 bit wrong");
  AST_PORT2: assert property (s_run |->
    network_status_bits[4] == $past(events.link_port2)) else $error("port2 bit wrong");
  AST_RST: assert property (disable iff (1'b0) !reset_n |=>
    network_status_bits == 16'h0000 && !supervised) else $error("reset left flags");
  AST_WD: assert property (s_wd |-> ##[1:2] (!network_enable && !request_accept))
    else $error("watchdog ignored");
  AST_WD_SUP: assert property (s_wd |=> !supervised) else $error("supervised kept");
  AST_DISCARD: assert property ($fell(request_accept) |=> !request_accept [*8])
    else $error("requests accepted again");
  AST_SUP: assert property ($rose(supervised) |->
    $past(events.modbus_request) || $past(psel && penable, 2))
    else $error("supervised without request");
  AST_SLVERR: assert property (pslverr |-> psel && penable) else $error("stray slverr");
endmodule : nss_supervisor_asserts
bind nss_supervisor nss_supervisor_asserts u_chk (
  .clock(clock), .reset_n(reset_n), .ce(ce), .psel(psel), .penable(penable), .pslverr(pslverr),
  .events(events), .network_status_bits(network_status_bits), .supervised(supervised),
  .network_enable(network_enable), .request_accept(request_accept)
);
`default_nettype wire

// >>> tb.sv
// self-checking testbench for the network state supervisor
`timescale 1ns/1ps
`default_nettype none
`include "nss_defines.svh"
module tb;
  logic               clock = 1'b0;
  logic               reset_n = 1'b0;
  logic               psel = 1'b0;
  logic               penable = 1'b0;
  logic               pwrite = 1'b0;
  logic               ce = 1'b1;
  logic [11:0]        paddr = 12'h000;
  logic [31:0]        pwdata = 32'h0;
  logic [31:0]        prdata, rd, ex;
  logic               pready, pslverr, err, sup, net_en, acc, irq;
  logic [15:0]        status;
  logic [1:0]         src;
  nss_pkg::nss_events_s events;
  logic [7:0]         cid [7] = '{8'h01, 8'h02, 8'hA0, 8'hC0, 8'hDE, 8'h12, 8'h34};
  int                 mismatches = 0;
  int                 compares = 0;
  always #10 clock = ~clock;
  nss_net_model net (.clock(clock), .events(events));
  // one-cycle tick keeps a 1 ms timeout at 1000 clocks
  nss_supervisor #(.TICK_CYCLES(1)) dut (.clock(clock), .reset_n(reset_n), .ce(ce),
    .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
    .pready(pready), .pslverr(pslverr), .prdata(prdata), .events(events),
    .network_status_bits(status), .supervised(sup), .network_enable(net_en),
    .request_accept(acc), .cid_source(src), .irq(irq));
  task automatic finish_test;
    $display("compares %0d mismatches %0d", compares, mismatches);
    if (mismatches == 0 && compares > 0) $display("DONE - PASS");
    else $display("DONE - FAIL");
    $finish;
  endtask : finish_test
  task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
    compares++;
    if (g !== e) begin
      mismatches++;
      $display("BAD %s exp %h got %h", nm, e, g);
    end
  endtask : chk
  task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
    @(posedge clock);
    psel   <= 1'b1;
    pwrite <= w;
    paddr  <= a;
    pwdata <= d;
    @(posedge clock) penable <= 1'b1;
    do @(posedge clock); while (pready !== 1'b1);
    rd = prdata;
    err = pslverr;
    psel    <= 1'b0;
    penable <= 1'b0;
  endtask : apb
  task automatic wr(input logic [11:0] a, input logic [31:0] d);
    apb(1'b1, a, d);
  endtask : wr
  task automatic rdc(input logic [11:0] a, input logic [31:0] e, input string nm);
    apb(1'b0, a, 32'h0);
    chk(nm, e, rd);
  endtask : rdc
  task automatic rst;
    @(posedge clock) reset_n <= 1'b0;
    repeat (3) @(posedge clock);
    reset_n <= 1'b1;
  endtask : rst
  initial begin
    #200000;
    mismatches++;
    finish_test();
  end
  initial begin
    rst();
    rdc(`NSS_OFF_STATE, 32'h0, "state");
    rdc(`NSS_OFF_STATUS, 32'h0, "status");
    rdc(`NSS_OFF_CONTROL, `NSS_CTL_RESET, "control");
    for (int i = 0; i < 8; i++) begin
      net.level(7, i[0]);
      net.level(6, i[1]);
      net.level(5, i[2]);
      ex = {27'h0, i[1], i[0], 1'b0, i[2], i[0] | i[1]};
      apb(1'b0, `NSS_OFF_STATUS, 32'h0);
      chk("status", ex, rd & 32'h0000001B);
      chk("mapped slverr", 32'h0, {31'h0, err});
    end
    wr(`NSS_OFF_CID_LEN, 32'h64);
    rdc(`NSS_OFF_CID_LEN, `NSS_CID_MAX, "cid length");
    wr(`NSS_OFF_CID_LEN, 32'h7);
    wr(`NSS_OFF_CID_PTR, 32'h0);
    foreach (cid[i]) wr(`NSS_OFF_CID_DATA, {24'h0, cid[i]});
    wr(`NSS_OFF_CID_PTR, 32'h0);
    foreach (cid[i]) rdc(`NSS_OFF_CID_DATA, {24'h0, cid[i]}, "cid byte");
    for (int s = 0; s < 4; s++) begin
      wr(`NSS_OFF_CONTROL, {29'h0, s[1:0], 1'b1});
      repeat (2) @(posedge clock);
      chk("source", 32'(s), {30'h0, src});
    end
    wr(`NSS_OFF_CID_LEN, 32'h0);
    repeat (2) @(posedge clock);
    chk("empty string source", 32'h0, {30'h0, src});
    apb(1'b0, 12'h0FC, 32'h0);
    chk("slverr", 32'h1, {31'h0, err});
    wr(`NSS_OFF_IRQ_MASK, 32'h4);
    apb(1'b0, `NSS_OFF_IRQ_STAT, 32'h0);
    wr(`NSS_OFF_TIMEOUT, 32'h1);
    net.pulse(3);
    rdc(`NSS_OFF_STATE, 32'h9, "active");
    chk("supervised", 32'h1, {31'h0, sup});
    repeat (900) @(posedge clock);
    rdc(`NSS_OFF_STATE, 32'h9, "still active");
    repeat (200) @(posedge clock);
    rdc(`NSS_OFF_STATE, 32'h0, "timed out");
    chk("irq", 32'h1, {31'h0, irq});
    rdc(`NSS_OFF_IRQ_STAT, 32'h6, "irq status");
    @(posedge clock);
    chk("irq clear", 32'h0, {31'h0, irq});
    wr(`NSS_OFF_TIMEOUT, 32'h0);
    net.pulse(3);
    rdc(`NSS_OFF_STATE, 32'h1, "unsupervised");
    net.level(1, 1'b1);
    net.pulse(2);
    net.pulse(3);
    rdc(`NSS_OFF_STATE, 32'h3, "idle");
    net.level(1, 1'b0);
    net.pulse(2);
    rdc(`NSS_OFF_STATE, 32'h0, "idle exit");
    @(posedge clock) ce <= 1'b0;
    net.pulse(3);
    @(posedge clock) ce <= 1'b1;
    rdc(`NSS_OFF_STATE, 32'h0, "frozen");
    wr(`NSS_OFF_CONTROL, 32'h0);
    net.level(4, 1'b1);
    rdc(`NSS_OFF_STATE, 32'h0, "no detect");
    net.level(4, 1'b0);
    wr(`NSS_OFF_CONTROL, 32'h1);
    net.level(4, 1'b1);
    rdc(`NSS_OFF_STATE, 32'h2, "error");
    net.level(4, 1'b0);
    rdc(`NSS_OFF_IRQ_STAT, 32'hA, "irq events");
    rst();
    net.pulse(0);
    @(posedge clock);
    chk("enable", 32'h0, {31'h0, net_en});
    net.pulse(3);
    rdc(`NSS_OFF_STATE, 32'h4, "exception");
    chk("accept", 32'h0, {31'h0, acc});
    rdc(`NSS_OFF_IRQ_STAT, 32'h11, "irq watchdog");
    finish_test();
  end
endmodule : tb
`default_nettype wire
